/* src/fsbs_consts.svh */
`ifndef FSBS_CONSTS_SVH
`define FSBS_CONSTS_SVH

// Register port
`define FSBS_ADDR_W        20
`define FSBS_DATA_W        16

// Register offsets
`define FSBS_OFS_STAT      20'hE0006
`define FSBS_OFS_EV_STS    20'hE0010
`define FSBS_OFS_EV_CLR    20'hE0012
`define FSBS_OFS_EV_EN     20'hE0014

// Status register field positions
`define FSBS_BIT_MIRROR    9
`define FSBS_BIT_BANK0     8
`define FSBS_SECT_MSB      1
`define FSBS_SECT_LSB      0
`define FSBS_RESV_HI_MSB   15
`define FSBS_RESV_HI_LSB   10
`define FSBS_RESV_MID_MSB  7
`define FSBS_RESV_MID_LSB  2

// Reset values, plus the all-sectors value loaded by an erase start
`define FSBS_STAT_RST      16'h0000
`define FSBS_SECT_ALL      2'h3
`define FSBS_SECT_NONE     2'h0
`define FSBS_EV_NONE       3'h0
`define FSBS_RDATA_IDLE    16'h0000

// Event bits of the interrupt status, clear and enable registers
`define FSBS_EV_W          3
`define FSBS_EV_ERASE_OK   0
`define FSBS_EV_WRITE_OK   1
`define FSBS_EV_FAIL       2

`endif

/* src/fsbs_pkg.sv */
package fsbs_pkg;

    // Bits of the sector-select and status register that hold state
    typedef struct packed {
        logic       bank0;
        logic [1:0] sect;
    } fsbs_stat_t;

    // Status bits qualified by the erase and suspend indications
    typedef struct packed {
        logic       bank0_err;
        logic [1:0] sect_err;
        logic       bank0_susp;
        logic [1:0] sect_susp;
    } fsbs_mean_t;

    typedef struct packed {
        fsbs_stat_t  stat;
        logic [2:0]  ev_sts;
        logic [2:0]  ev_en;
        logic [15:0] rdata;
        logic        irq;
        logic [1:0]  sel;
        fsbs_mean_t  mean;
    } fsbs_state_t;

endpackage : fsbs_pkg

/* src/fsbs_top.sv */
// Strobed register access was left to the implementer.
`include "fsbs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fsbs_top (
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST_N,
    input  wire logic                    CLK_EN,
    input  wire logic [`FSBS_ADDR_W-1:0] REG_ADDR,
    input  wire logic [`FSBS_DATA_W-1:0] REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [`FSBS_DATA_W-1:0] REG_RDATA,
    input  wire logic                    ERASE_IND,
    input  wire logic                    SUSPEND_IND,
    input  wire logic                    ERASE_START,
    input  wire logic                    ERASE_END,
    input  wire logic                    WRITE_END,
    input  wire logic                    OP_FAIL,
    output logic      [1:0]              SECT_SELECT,
    output logic                         BANK0_ERASE_ERR,
    output logic      [1:0]              SECT_ERASE_ERR,
    output logic                         BANK0_SUSPENDED,
    output logic      [1:0]              SECT_SUSPENDED,
    output logic                         IRQ
);

    fsbs_pkg::fsbs_state_t s_q;
    fsbs_pkg::fsbs_state_t s_d;

    logic                  wr_stat;
    logic                  wr_clr;
    logic                  wr_en;
    logic [`FSBS_EV_W-1:0] ev_set;

    // Same decode serves the write and the read path
    function automatic logic fsbs_hit(
        input logic [`FSBS_ADDR_W-1:0] addr,
        input logic [`FSBS_ADDR_W-1:0] ofs
    );
        fsbs_hit = (addr == ofs);
    endfunction : fsbs_hit

    // Reserved bits and the mirror are rebuilt on every read, never stored
    function automatic logic [`FSBS_DATA_W-1:0] fsbs_stat_word(
        input fsbs_pkg::fsbs_stat_t st
    );
        logic [`FSBS_DATA_W-1:0] w;
        w = `FSBS_STAT_RST;
        w[`FSBS_BIT_BANK0] = st.bank0;
        w[`FSBS_BIT_MIRROR] = st.bank0;
        w[`FSBS_SECT_MSB:`FSBS_SECT_LSB] = st.sect;
        fsbs_stat_word = w;
    endfunction : fsbs_stat_word

    assign wr_stat = REG_WR && fsbs_hit(REG_ADDR, `FSBS_OFS_STAT);
    assign wr_clr  = REG_WR && fsbs_hit(REG_ADDR, `FSBS_OFS_EV_CLR);
    assign wr_en   = REG_WR && fsbs_hit(REG_ADDR, `FSBS_OFS_EV_EN);

    always_comb begin
        s_d = s_q;

        // Software may only set the select bits; reserved data is dropped
        if (wr_stat) begin
            s_d.stat.bank0 = s_q.stat.bank0 | REG_WDATA[`FSBS_BIT_BANK0];
            s_d.stat.sect  = s_q.stat.sect
                           | REG_WDATA[`FSBS_SECT_MSB:`FSBS_SECT_LSB];
        end

        // Successful completions clear; a failed one leaves the flags as error marks
        if (ERASE_END && !OP_FAIL) begin
            s_d.stat.bank0 = 1'b0;
        end
        if (WRITE_END && !OP_FAIL) begin
            s_d.stat.sect = `FSBS_SECT_NONE;
        end

        // An erase start is applied last so it wins over any clear
        if (ERASE_START) begin
            s_d.stat.bank0 = 1'b1;
            s_d.stat.sect  = `FSBS_SECT_ALL;
        end

        s_d.sel = s_d.stat.sect;

        // Qualifiers come straight from same-clock control logic, no synchroniser
        s_d.mean.bank0_err  = ERASE_IND && s_d.stat.bank0;
        s_d.mean.sect_err   = ERASE_IND ? s_d.stat.sect : `FSBS_SECT_NONE;
        s_d.mean.bank0_susp = !ERASE_IND && SUSPEND_IND && s_d.stat.bank0;
        s_d.mean.sect_susp  = (!ERASE_IND && SUSPEND_IND) ? s_d.stat.sect
                            : `FSBS_SECT_NONE;

        ev_set = `FSBS_EV_NONE;
        ev_set[`FSBS_EV_ERASE_OK] = ERASE_END && !OP_FAIL;
        ev_set[`FSBS_EV_WRITE_OK] = WRITE_END && !OP_FAIL;
        ev_set[`FSBS_EV_FAIL]     = (ERASE_END || WRITE_END) && OP_FAIL;

        // Set wins over a clear in the same cycle so no event is lost
        if (wr_clr) begin
            s_d.ev_sts = s_q.ev_sts & ~REG_WDATA[`FSBS_EV_W-1:0];
        end
        s_d.ev_sts = s_d.ev_sts | ev_set;
        if (wr_en) begin
            s_d.ev_en = REG_WDATA[`FSBS_EV_W-1:0];
        end
        s_d.irq = |(s_d.ev_sts & s_d.ev_en);

        // Read data stands only in the cycle after the strobe
        s_d.rdata = `FSBS_RDATA_IDLE;
        if (REG_RD) begin
            if (fsbs_hit(REG_ADDR, `FSBS_OFS_STAT)) begin
                s_d.rdata = fsbs_stat_word(s_q.stat);
            end else if (fsbs_hit(REG_ADDR, `FSBS_OFS_EV_STS)) begin
                s_d.rdata[`FSBS_EV_W-1:0] = s_q.ev_sts;
            end else if (fsbs_hit(REG_ADDR, `FSBS_OFS_EV_EN)) begin
                s_d.rdata[`FSBS_EV_W-1:0] = s_q.ev_en;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q.stat.bank0 <= 1'b0;
            s_q.stat.sect  <= `FSBS_SECT_NONE;
            s_q.ev_sts     <= `FSBS_EV_NONE;
            s_q.ev_en      <= `FSBS_EV_NONE;
            s_q.rdata      <= `FSBS_RDATA_IDLE;
            s_q.irq        <= 1'b0;
            s_q.sel        <= `FSBS_SECT_NONE;
            s_q.mean       <= '0;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA       = s_q.rdata;
    assign SECT_SELECT     = s_q.sel;
    assign BANK0_ERASE_ERR = s_q.mean.bank0_err;
    assign SECT_ERASE_ERR  = s_q.mean.sect_err;
    assign BANK0_SUSPENDED = s_q.mean.bank0_susp;
    assign SECT_SUSPENDED  = s_q.mean.sect_susp;
    assign IRQ             = s_q.irq;

    default clocking dflt_cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    a_mirror_copy: assert property (
        CLK_EN && REG_RD && REG_ADDR == `FSBS_OFS_STAT
        |=> REG_RDATA[`FSBS_BIT_MIRROR] == REG_RDATA[`FSBS_BIT_BANK0]
            && REG_RDATA[`FSBS_BIT_BANK0] == $past(s_q.stat.bank0))
        else $error("mirror bit differs from bank 0 status");

    a_erase_sets_bank: assert property (
        CLK_EN && ERASE_START |=> s_q.stat.bank0)
        else $error("bank 0 status not set by erase start");

    a_erase_ok_clear: assert property (
        CLK_EN && ERASE_END && !OP_FAIL && !ERASE_START
        |=> !s_q.stat.bank0)
        else $error("bank 0 status not cleared after clean erase");

    a_erase_sets_sect: assert property (
        CLK_EN && ERASE_START |=> SECT_SELECT == `FSBS_SECT_ALL)
        else $error("sector bits not set by erase start");

    a_write_ok_clear: assert property (
        CLK_EN && WRITE_END && !OP_FAIL && !ERASE_START
        |=> s_q.stat.sect == `FSBS_SECT_NONE)
        else $error("sector bits not cleared after clean write");

    a_err_meaning: assert property (
        CLK_EN && ERASE_IND
        |=> BANK0_ERASE_ERR == s_q.stat.bank0
            && SECT_ERASE_ERR == s_q.stat.sect && !BANK0_SUSPENDED)
        else $error("erase error outputs do not follow status");

    a_susp_meaning: assert property (
        CLK_EN && !ERASE_IND && SUSPEND_IND
        |=> BANK0_SUSPENDED == s_q.stat.bank0
            && SECT_SUSPENDED == s_q.stat.sect && !BANK0_ERASE_ERR)
        else $error("suspend outputs do not follow status");

    a_idle_meaning: assert property (
        CLK_EN && !ERASE_IND && !SUSPEND_IND
        |=> !BANK0_ERASE_ERR && !BANK0_SUSPENDED
            && SECT_ERASE_ERR == `FSBS_SECT_NONE
            && SECT_SUSPENDED == `FSBS_SECT_NONE)
        else $error("qualified outputs active without qualifier");

    a_irq_level: assert property (
        CLK_EN && OP_FAIL && ERASE_END ##1 s_q.ev_en[`FSBS_EV_FAIL]
        |-> IRQ)
        else $error("interrupt low with enabled failure event");

    // Register read path
    a_rdata_idle: assert property (
        CLK_EN && !REG_RD |=> REG_RDATA == `FSBS_RDATA_IDLE)
        else $error("read data not idle outside a read");

    a_resv_zero: assert property (
        CLK_EN && REG_RD && REG_ADDR == `FSBS_OFS_STAT
        |=> REG_RDATA[`FSBS_RESV_HI_MSB:`FSBS_RESV_HI_LSB] == '0
            && REG_RDATA[`FSBS_RESV_MID_MSB:`FSBS_RESV_MID_LSB] == '0)
        else $error("reserved status bits read nonzero");

    a_stat_read: assert property (
        CLK_EN && REG_RD && REG_ADDR == `FSBS_OFS_STAT
        |=> REG_RDATA == fsbs_stat_word($past(s_q.stat)))
        else $error("status word read wrong");

    a_evsts_read: assert property (
        CLK_EN && REG_RD && REG_ADDR == `FSBS_OFS_EV_STS
        |=> REG_RDATA[`FSBS_EV_W-1:0] == $past(s_q.ev_sts)
            && REG_RDATA[`FSBS_DATA_W-1:`FSBS_EV_W] == '0)
        else $error("event status read wrong");

    a_even_read: assert property (
        CLK_EN && REG_RD && REG_ADDR == `FSBS_OFS_EV_EN
        |=> REG_RDATA[`FSBS_EV_W-1:0] == $past(s_q.ev_en)
            && REG_RDATA[`FSBS_DATA_W-1:`FSBS_EV_W] == '0)
        else $error("event enable read wrong");

    a_unmapped_zero: assert property (
        CLK_EN && REG_RD && REG_ADDR != `FSBS_OFS_STAT
            && REG_ADDR != `FSBS_OFS_EV_STS
            && REG_ADDR != `FSBS_OFS_EV_EN
        |=> REG_RDATA == `FSBS_RDATA_IDLE)
        else $error("unmapped read returned data");

    // A low enable must hold every flop, the interrupt included
    a_freeze_state: assert property (
        !CLK_EN |=> $stable(s_q))
        else $error("state moved while clock enable low");

    a_irq_follows: assert property (
        IRQ == |(s_q.ev_sts & s_q.ev_en))
        else $error("interrupt differs from enabled status");

    a_sel_follows: assert property (
        SECT_SELECT == s_q.stat.sect)
        else $error("sector select differs from status");

    // Status flag behaviour
    a_fail_keeps_bank: assert property (
        CLK_EN && ERASE_END && OP_FAIL && s_q.stat.bank0
        |=> s_q.stat.bank0)
        else $error("failed erase cleared bank 0 status");

    a_fail_keeps_sect: assert property (
        CLK_EN && WRITE_END && OP_FAIL
        |=> (s_q.stat.sect & $past(s_q.stat.sect))
            == $past(s_q.stat.sect))
        else $error("failed write cleared sector bits");

    a_ev_fail_set: assert property (
        CLK_EN && (ERASE_END || WRITE_END) && OP_FAIL
        |=> s_q.ev_sts[`FSBS_EV_FAIL])
        else $error("failure event not recorded");

    a_ev_erase_set: assert property (
        CLK_EN && ERASE_END && !OP_FAIL |=> s_q.ev_sts[`FSBS_EV_ERASE_OK])
        else $error("erase done event not recorded");

    a_ev_write_set: assert property (
        CLK_EN && WRITE_END && !OP_FAIL |=> s_q.ev_sts[`FSBS_EV_WRITE_OK])
        else $error("write done event not recorded");

    a_sw_sets_sect: assert property (
        CLK_EN && wr_stat && !(WRITE_END && !OP_FAIL)
        |=> (s_q.stat.sect & $past(REG_WDATA[`FSBS_SECT_MSB:`FSBS_SECT_LSB]))
            == $past(REG_WDATA[`FSBS_SECT_MSB:`FSBS_SECT_LSB]))
        else $error("software sector select lost");

    a_sw_sets_bank: assert property (
        CLK_EN && wr_stat && REG_WDATA[`FSBS_BIT_BANK0]
            && !(ERASE_END && !OP_FAIL)
        |=> s_q.stat.bank0)
        else $error("software bank 0 set lost");

    a_en_write: assert property (
        CLK_EN && wr_en |=> s_q.ev_en == $past(REG_WDATA[`FSBS_EV_W-1:0]))
        else $error("event enable write lost");

    a_clr_works: assert property (
        CLK_EN && wr_clr && !ERASE_END && !WRITE_END
        |=> (s_q.ev_sts & $past(REG_WDATA[`FSBS_EV_W-1:0]))
            == `FSBS_EV_NONE)
        else $error("event clear did not clear");

    a_set_beats_clr: assert property (
        CLK_EN && wr_clr && (ERASE_END || WRITE_END) && OP_FAIL
        |=> s_q.ev_sts[`FSBS_EV_FAIL])
        else $error("clear swallowed a failure event");

    a_flag_excl: assert property (
        !(BANK0_ERASE_ERR && BANK0_SUSPENDED)
        && (SECT_ERASE_ERR & SECT_SUSPENDED) == `FSBS_SECT_NONE)
        else $error("error and suspend shown together");

    a_bank_holds: assert property (
        CLK_EN && s_q.stat.bank0 && !ERASE_END
        |=> s_q.stat.bank0)
        else $error("bank 0 status dropped without erase end");

    a_sect_holds: assert property (
        CLK_EN && !WRITE_END
        |=> (s_q.stat.sect & $past(s_q.stat.sect))
            == $past(s_q.stat.sect))
        else $error("sector bits dropped without write end");

    a_start_wins: assert property (
        CLK_EN && ERASE_START && (ERASE_END || WRITE_END) && !OP_FAIL
        |=> s_q.stat.bank0
            && s_q.stat.sect == `FSBS_SECT_ALL)
        else $error("erase start lost against a clear");

    a_irq_masked: assert property (
        CLK_EN && wr_en && REG_WDATA[`FSBS_EV_W-1:0] == `FSBS_EV_NONE
        |=> !IRQ)
        else $error("interrupt high with all events masked");

    a_susp_needs_bank: assert property (
        BANK0_SUSPENDED |-> s_q.stat.bank0)
        else $error("bank suspended shown without status");

    a_err_needs_bank: assert property (
        BANK0_ERASE_ERR |-> s_q.stat.bank0)
        else $error("bank error shown without status");

endmodule : fsbs_top

`default_nettype wire

/* verif/tb_top.sv */
`include "fsbs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        CORE_CLK, RST_N, CLK_EN, REG_WR, REG_RD, IRQ;
    logic        ERASE_IND, SUSPEND_IND, ERASE_START, ERASE_END, WRITE_END, OP_FAIL;
    logic [19:0] REG_ADDR;
    logic [15:0] REG_WDATA, REG_RDATA;
    logic [1:0]  SECT_SELECT, SECT_ERASE_ERR, SECT_SUSPENDED;
    logic        BANK0_ERASE_ERR, BANK0_SUSPENDED;
    int          n_mismatch, n_checks;

    fsbs_top i_fsbs_top (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .ERASE_IND(ERASE_IND), .SUSPEND_IND(SUSPEND_IND),
        .ERASE_START(ERASE_START), .ERASE_END(ERASE_END), .WRITE_END(WRITE_END),
        .OP_FAIL(OP_FAIL), .SECT_SELECT(SECT_SELECT), .BANK0_ERASE_ERR(BANK0_ERASE_ERR),
        .SECT_ERASE_ERR(SECT_ERASE_ERR), .BANK0_SUSPENDED(BANK0_SUSPENDED),
        .SECT_SUSPENDED(SECT_SUSPENDED), .IRQ(IRQ));

    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Sequencer outputs packed as sel, bank err, sector err, bank susp, sector susp
    function automatic logic [15:0] outs();
        return {8'h00, SECT_SELECT, BANK0_ERASE_ERR, SECT_ERASE_ERR, BANK0_SUSPENDED,
                SECT_SUSPENDED};
    endfunction : outs

    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [19:0] a, input logic [15:0] exp);
        @(posedge CORE_CLK);
        REG_RD <= 1'b1; REG_ADDR <= a;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 chk(REG_RDATA, exp);
    endtask : rd

    // Kind bit 0 starts an erase, bit 1 ends an erase, bit 2 ends a write
    task automatic ev(input logic [2:0] k, input logic fail);
        @(posedge CORE_CLK);
        ERASE_START <= k[0]; ERASE_END <= k[1]; WRITE_END <= k[2]; OP_FAIL <= fail;
        @(posedge CORE_CLK);
        {ERASE_START, ERASE_END, WRITE_END} <= 3'h0;
        #1;
    endtask : ev

    task automatic ind(input logic e, input logic s);
        @(posedge CORE_CLK);
        ERASE_IND <= e; SUSPEND_IND <= s;
    endtask : ind

    task automatic t_reset();
        rd(`FSBS_OFS_STAT, 16'h0000);
        chk(outs(), 16'h0000);
        rd(20'h00000, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_swset();
        wr(`FSBS_OFS_STAT, 16'h0103);
        rd(`FSBS_OFS_STAT, 16'h0303);
        wr(`FSBS_OFS_STAT, 16'h0000);
        rd(`FSBS_OFS_STAT, 16'h0303);
        ev(3'h2, 1'b0);
        rd(`FSBS_OFS_STAT, 16'h0003);
        ev(3'h4, 1'b0);
        rd(`FSBS_OFS_STAT, 16'h0000);
        $display("test software set done");
    endtask : t_swset

    task automatic t_erase();
        ind(1'b1, 1'b0);
        wr(`FSBS_OFS_STAT, 16'h0003);
        ev(3'h1, 1'b0);
        chk(outs(), 16'h00F8);
        rd(`FSBS_OFS_STAT, 16'h0303);
        ev(3'h2, 1'b1);
        rd(`FSBS_OFS_STAT, 16'h0303);
        ind(1'b0, 1'b1);
        ev(3'h2, 1'b0);
        chk(outs(), 16'h00C3);
        ev(3'h1, 1'b0);
        chk(outs(), 16'h00C7);
        ind(1'b0, 1'b0);
        @(posedge CORE_CLK);
        #1 chk(outs(), 16'h00C0);
        ev(3'h4, 1'b1);
        rd(`FSBS_OFS_STAT, 16'h0303);
        ev(3'h6, 1'b0);
        rd(`FSBS_OFS_STAT, 16'h0000);
        $display("test erase done");
    endtask : t_erase

    task automatic t_irq();
        wr(`FSBS_OFS_EV_CLR, 16'h0007);
        wr(`FSBS_OFS_EV_EN, 16'h0001);
        chk({15'h0000, IRQ}, 16'h0000);
        ev(3'h2, 1'b0);
        chk({15'h0000, IRQ}, 16'h0001);
        ev(3'h4, 1'b1);
        rd(`FSBS_OFS_EV_STS, 16'h0005);
        wr(`FSBS_OFS_EV_EN, 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        wr(`FSBS_OFS_EV_EN, 16'h0004);
        chk({15'h0000, IRQ}, 16'h0001);
        rd(`FSBS_OFS_EV_EN, 16'h0004);
        rd(`FSBS_OFS_EV_CLR, 16'h0000);
        wr(`FSBS_OFS_EV_CLR, 16'h0004);
        chk({15'h0000, IRQ}, 16'h0000);
        rd(`FSBS_OFS_EV_STS, 16'h0001);
        $display("test interrupt done");
    endtask : t_irq

    task automatic t_freeze();
        @(posedge CORE_CLK);
        CLK_EN <= 1'b0;
        ev(3'h1, 1'b0);
        wr(`FSBS_OFS_STAT, 16'h0103);
        chk(outs(), 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        @(posedge CORE_CLK);
        CLK_EN <= 1'b1;
        rd(`FSBS_OFS_STAT, 16'h0000);
        $display("test clock enable done");
    endtask : t_freeze

    task automatic t_rerst();
        wr(`FSBS_OFS_STAT, 16'h0103);
        wr(`FSBS_OFS_EV_EN, 16'h0007);
        chk({15'h0000, IRQ}, 16'h0001);
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        chk(outs(), 16'h0000);
        chk({15'h0000, IRQ}, 16'h0000);
        rd(`FSBS_OFS_STAT, 16'h0000);
        rd(`FSBS_OFS_EV_EN, 16'h0000);
        rd(`FSBS_OFS_EV_STS, 16'h0000);
        $display("test mid-run reset done");
    endtask : t_rerst

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // Hang guard: the whole run needs far fewer cycles than this
    initial begin
        repeat (5000) @(posedge CORE_CLK);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        n_mismatch = 0; n_checks = 0;
        RST_N = 1'b0; CLK_EN = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0;
        REG_ADDR = 20'h00000; REG_WDATA = 16'h0000; ERASE_IND = 1'b0;
        SUSPEND_IND = 1'b0; ERASE_START = 1'b0; ERASE_END = 1'b0;
        WRITE_END = 1'b0; OP_FAIL = 1'b0;
        repeat (16) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        t_reset();
        t_swset();
        t_erase();
        t_irq();
        t_freeze();
        t_rerst();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
